// [src/spi_eeprom_read_write.sv]
/*
  serial eeprom array access: read with whole-array wrap, page-buffered write,
  write-enable latch, busy flag and self-timed write cycle.
  assumes the master keeps serial_clock still while device_select_n is high,
  and that status_load_i comes from logic on clk_i.
*/
`timescale 1ns/1ns
`default_nettype none
module spi_eeprom_read_write
  import eeprom_pkg::*;
#(
  parameter int ADDR_BITS = ADDR_BITS_16K,
  parameter int WRITE_CYCLE_COUNT = WRITE_CYCLE_CLKS,
  parameter logic [7:0] OP_READ = OP_READ_DEFAULT,
  parameter logic [7:0] OP_WRITE = OP_WRITE_DEFAULT,
  parameter logic [7:0] OP_WRITE_ENABLE_CMD = OP_WRITE_ENABLE_CMD_DEFAULT
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic serial_clock_i,
  input wire logic device_select_n_i,
  input wire logic serial_in_i,
  input wire logic status_load_i,
  input wire logic [2:0] status_value_i,
  output logic serial_out_o,
  output logic serial_out_en_o,
  output logic write_busy_flag_o,
  output logic write_enable_latch_o,
  output logic status_write_lock_o,
  output logic block_protect_hi_o,
  output logic block_protect_lo_o
);
  localparam int DEPTH = 1 << ADDR_BITS;
  localparam int TW = $clog2(WRITE_CYCLE_COUNT + 1);
  localparam logic [TW-1:0] TIMER_LOAD = TW'(WRITE_CYCLE_COUNT - 1);

  generate
    if ((ADDR_BITS != ADDR_BITS_16K && ADDR_BITS != ADDR_BITS_8K) || WRITE_CYCLE_COUNT < 1) begin : g_bad
      $error("unsupported address width or write cycle count");
    end
  endgenerate

  typedef struct packed {
    phase_t phase;
    logic [3:0] bitcnt;
    logic [ADDR_FIELD_BITS-1:0] shift;
    logic op_read;
    logic op_write;
    logic op_write_enable_cmd;
    logic wr_ok;
    logic rd_active;
    logic [ADDR_BITS-1:0] addr;
    logic [PAGE_BITS-1:0] wlow;
    logic got_byte;
    logic [7:0] tx;
    logic [PAGE_BYTES-1:0][7:0] pbuf;
    logic [PAGE_BYTES-1:0] pvalid;
    logic wel_m;
    logic wel_s;
    logic busy_m;
    logic busy_s;
  } link_t;

  typedef struct packed {
    logic cs_m;
    logic cs_s;
    logic cs_d;
    logic rd_m;
    logic rd_s;
    logic out_en;
    logic busy;
    logic write_enable_latch;
    logic [TW-1:0] timer;
    logic [2:0] status;
  } core_t;

  link_t link;
  link_t next_link;
  core_t core;
  core_t next_core;
  logic frame_run;
  logic serial_out;
  logic rd_live;
  logic write_go;
  logic write_enable_cmd_go;
  logic cs_rise;
  logic [7:0] mem [DEPTH];

  // bp bits pick protected top part
  function automatic logic is_protected(input logic [1:0] bp, input logic [ADDR_BITS-1:0] a);
    logic hit;
    hit = 1'b0;
    case (bp)
      BP_NONE: hit = 1'b0;
      BP_QUARTER: hit = (a[ADDR_BITS-1:ADDR_BITS-2] == 2'h3);
      BP_HALF: hit = a[ADDR_BITS-1];
      BP_ALL: hit = 1'b1;
      default: hit = 1'b0;
    endcase
    return hit;
  endfunction

  // cleared while deselected, marks edges inside the current frame
  always_ff @(posedge serial_clock_i or posedge device_select_n_i or posedge rst_i) begin
    if (device_select_n_i || rst_i) begin
      frame_run <= 1'b0;
    end else begin
      frame_run <= 1'b1;
    end
  end

  always_comb begin
    logic [3:0] cnt;
    phase_t ph;
    logic [ADDR_FIELD_BITS-1:0] sh;
    logic [ADDR_BITS-1:0] nxt;
    cnt = frame_run ? link.bitcnt : 4'h0;
    ph = frame_run ? link.phase : P_OP;
    sh = {link.shift[ADDR_FIELD_BITS-2:0], serial_in_i};
    nxt = link.addr + 1'b1;
    next_link = link;
    next_link.wel_m = core.write_enable_latch;
    next_link.wel_s = link.wel_m;
    next_link.busy_m = core.busy;
    next_link.busy_s = link.busy_m;
    next_link.shift = sh;
    next_link.bitcnt = cnt + 4'h1;
    if (!frame_run) begin
      next_link.op_read = 1'b0;
      next_link.op_write = 1'b0;
      next_link.op_write_enable_cmd = 1'b0;
      next_link.wr_ok = 1'b0;
      next_link.rd_active = 1'b0;
      next_link.got_byte = 1'b0;
      next_link.pvalid = '0;
    end
    next_link.phase = ph;
    case (ph)
      P_OP: begin
        if (cnt == 4'h7) begin
          next_link.bitcnt = 4'h0;
          next_link.op_read = (sh[7:0] == OP_READ) && !link.busy_s;
          next_link.op_write = (sh[7:0] == OP_WRITE);
          // enable latch set and no cycle running
          next_link.wr_ok = link.wel_s && !link.busy_s;
          next_link.op_write_enable_cmd = (sh[7:0] == OP_WRITE_ENABLE_CMD);
          if (next_link.op_read || (next_link.op_write && next_link.wr_ok)) begin
            next_link.phase = P_ADDR;
          end else begin
            next_link.phase = P_SKIP;
          end
        end
      end
      P_ADDR: begin
        if (cnt == 4'hF) begin
          // low address bits only, any start byte
          next_link.addr = sh[ADDR_BITS-1:0];
          next_link.wlow = sh[PAGE_BITS-1:0];
          next_link.bitcnt = 4'h0;
          next_link.phase = P_DATA;
          if (link.op_read) begin
            next_link.rd_active = 1'b1;
            next_link.tx = mem[sh[ADDR_BITS-1:0]];
          end
        end
      end
      P_DATA: begin
        if (cnt == 4'h7) begin
          next_link.bitcnt = 4'h0;
          if (link.op_read) begin
            // next byte, wraps at top of array
            next_link.addr = nxt;
            next_link.tx = mem[nxt];
          end else begin
            next_link.pbuf[link.wlow] = sh[7:0];
            next_link.pvalid[link.wlow] = 1'b1;
            next_link.wlow = link.wlow + 1'b1;
            next_link.got_byte = 1'b1;
          end
        end
      end
      P_SKIP: begin
        // any bit after the opcode spoils a write-enable
        next_link.op_write_enable_cmd = 1'b0;
        next_link.bitcnt = cnt;
      end
      default: begin
        next_link.phase = P_SKIP;
      end
    endcase
  end

  // inputs sampled on rising serial clock
  always_ff @(posedge serial_clock_i or posedge rst_i) begin
    if (rst_i) begin
      link <= '0;
    end else begin
      link <= next_link;
    end
  end

  // output bit changes on falling serial clock
  always_ff @(negedge serial_clock_i or posedge rst_i) begin
    if (rst_i) begin
      serial_out <= 1'b1;
    end else begin
      serial_out <= link.tx[~link.bitcnt[2:0]];
    end
  end

  // link state is quiet once select is high, so it is read after the rise
  assign rd_live = link.rd_active & frame_run;
  assign cs_rise = core.cs_s & ~core.cs_d;
  assign write_enable_cmd_go = link.op_write_enable_cmd && (link.phase == P_SKIP) && (link.bitcnt == 4'h0);
  // whole bytes only, page outside protected region
  assign write_go = link.op_write && link.wr_ok && (link.phase == P_DATA) &&
                    (link.bitcnt == 4'h0) && link.got_byte &&
                    !is_protected(core.status[1:0], link.addr);

  always_comb begin
    next_core = core;
    next_core.cs_m = device_select_n_i;
    next_core.cs_s = core.cs_m;
    next_core.cs_d = core.cs_s;
    next_core.rd_m = rd_live;
    next_core.rd_s = core.rd_m;
    // drive only inside an accepted read frame
    next_core.out_en = ~core.cs_s & core.rd_s;
    if (status_load_i && !core.busy) begin
      next_core.status = status_value_i;
    end
    if (core.busy) begin
      if (core.timer == '0) begin
        // cycle over, busy and latch drop
        next_core.busy = 1'b0;
        next_core.write_enable_latch = 1'b0;
      end else begin
        next_core.timer = core.timer - 1'b1;
      end
    end
    if (cs_rise) begin
      if (write_enable_cmd_go && !core.busy) begin
        next_core.write_enable_latch = 1'b1;
      end
      if (write_go && !core.busy) begin
        next_core.busy = 1'b1;
        next_core.timer = TIMER_LOAD;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      core <= '0;
      core.cs_m <= 1'b1;
      core.cs_s <= 1'b1;
      core.cs_d <= 1'b1;
      core.status <= STATUS_RESET;
    end else begin
      core <= next_core;
    end
  end

  // array comes up erased; programs only loaded bytes of the page
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      for (int i = 0; i < DEPTH; i++) begin
        mem[i] <= ERASED_BYTE;
      end
    end else if (cs_rise && write_go && !core.busy) begin
      for (int i = 0; i < PAGE_BYTES; i++) begin
        if (link.pvalid[i]) begin
          mem[{link.addr[ADDR_BITS-1:PAGE_BITS], PAGE_BITS'(i)}] <= link.pbuf[i];
        end
      end
    end
  end

  assign serial_out_o = serial_out;
  assign serial_out_en_o = core.out_en;
  assign write_busy_flag_o = core.busy;
  assign write_enable_latch_o = core.write_enable_latch;
  assign status_write_lock_o = core.status[2];
  assign block_protect_hi_o = core.status[1];
  assign block_protect_lo_o = core.status[0];
endmodule
`default_nettype wire

// [src/eeprom_pkg.sv]
/*
  constants shared by the serial eeprom array-access block.
  assumes a 250 MHz core clock; opcodes and write cycle time are defaults only.
*/
package eeprom_pkg;
  localparam int CLK_PERIOD_NS = 4;
  localparam int ADDR_FIELD_BITS = 16;
  localparam int ADDR_BITS_16K = 11;
  localparam int ADDR_BITS_8K = 10;
  localparam int PAGE_BYTES = 32;
  localparam int PAGE_BITS = 5;
  localparam int BYTE_BITS = 8;
  localparam logic [7:0] ERASED_BYTE = 8'hFF;
  localparam logic [2:0] STATUS_RESET = 3'h0;
  localparam logic [7:0] OP_READ_DEFAULT = 8'h03;
  localparam logic [7:0] OP_WRITE_DEFAULT = 8'h02;
  localparam logic [7:0] OP_WRITE_ENABLE_CMD_DEFAULT = 8'h06;
  localparam int WRITE_CYCLE_TIME_NS = 10000000;
  localparam int WRITE_CYCLE_CLKS = (WRITE_CYCLE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [1:0] BP_NONE = 2'h0;
  localparam logic [1:0] BP_QUARTER = 2'h1;
  localparam logic [1:0] BP_HALF = 2'h2;
  localparam logic [1:0] BP_ALL = 2'h3;
  typedef enum logic [1:0] {
    P_OP = 2'b00,
    P_ADDR = 2'b01,
    P_DATA = 2'b10,
    P_SKIP = 2'b11
  } phase_t;
endpackage

// [tb/spi_master_model.sv]
/*
  serial bus master model that shifts frames into the eeprom block.
  assumes mode 0: clock low and still between frames, data set while low.
*/
`timescale 1ns/1ns
`default_nettype none
module spi_master_model (
  output logic sck_o,
  output logic sel_n_o,
  output logic mosi_o,
  input wire logic miso_i
);
  logic [7:0] rx[$];
  initial begin
    sck_o = 1'b0;
    sel_n_o = 1'b1;
    mosi_o = 1'b0;
  end
  task automatic xfer(input logic [7:0] tx[$], input int nrd, input int extra);
    logic [7:0] b;
    rx = {};
    #17 sel_n_o = 1'b0;
    for (int i = 0; i < tx.size() + nrd + (extra > 0); i++) begin
      b = (i < tx.size()) ? tx[i] : 8'h5A;
      for (int k = 7; k >= 0; k--) begin
        if (i < tx.size() + nrd || 7 - k < extra) begin
          mosi_o = b[k];
          #16 sck_o = 1'b1;
          b[k] = miso_i;
          #16 sck_o = 1'b0;
        end
      end
      if (i >= tx.size() && i < tx.size() + nrd) rx.push_back(b);
    end
    #16 sel_n_o = 1'b1;
    mosi_o = ~mosi_o;
    #32;
  endtask
endmodule
`default_nettype wire

// [tb/spi_eeprom_read_write_assertions.sv]
/*
  port checker for the eeprom block.
  assumes one clk_i domain with synchronous active-high rst_i.
*/
`timescale 1ns/1ns
`default_nettype none
module spi_eeprom_read_write_assertions #(
  parameter int WRITE_CYCLE_COUNT = 20
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic serial_clock_i,
  input wire logic device_select_n_i,
  input wire logic serial_in_i,
  input wire logic status_load_i,
  input wire logic [2:0] status_value_i,
  input wire logic serial_out_o,
  input wire logic serial_out_en_o,
  input wire logic write_busy_flag_o,
  input wire logic write_enable_latch_o,
  input wire logic status_write_lock_o,
  input wire logic block_protect_hi_o,
  input wire logic block_protect_lo_o
);
  int cnt;
  wire [2:0] st = {status_write_lock_o, block_protect_hi_o, block_protect_lo_o};
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  always_ff @(posedge clk_i) begin
    cnt <= (rst_i || !write_busy_flag_o) ? 0 : cnt + 1;
  end
  a_busy_len: assert property ($fell(write_busy_flag_o) |-> cnt == WRITE_CYCLE_COUNT)
    else $error("write cycle length wrong");
  a_latch_clear: assert property ($fell(write_busy_flag_o) |-> !write_enable_latch_o)
    else $error("enable latch kept after write");
  a_busy_needs_latch: assert property ($rose(write_busy_flag_o) |-> $past(write_enable_latch_o))
    else $error("write ran without enable latch");
  a_busy_at_deselect: assert property ($rose(write_busy_flag_o) |-> device_select_n_i)
    else $error("write started while selected");
  a_latch_at_deselect: assert property ($rose(write_enable_latch_o) |-> device_select_n_i)
    else $error("latch set mid frame");
  a_no_read_busy: assert property ($rose(serial_out_en_o) |-> !write_busy_flag_o)
    else $error("read answered during write");
  a_out_released: assert property (device_select_n_i [*5] |-> !serial_out_en_o)
    else $error("output driven while deselected");
  a_status_load: assert property (status_load_i && !write_busy_flag_o |=> st == $past(status_value_i))
    else $error("status bits not loaded");
  a_status_hold: assert property (!(status_load_i && !write_busy_flag_o) |=> $stable(st))
    else $error("status bits changed unasked");
  a_reset_state: assert property (disable iff (1'b0) rst_i [*2] |-> st == 3'h0 && serial_out_o
    && !write_busy_flag_o && !write_enable_latch_o && !serial_out_en_o)
    else $error("reset state wrong");
  cover property ($fell(write_busy_flag_o));
  cover property ($rose(serial_out_en_o));
  cover property ($rose(write_enable_latch_o));
endmodule
bind spi_eeprom_read_write spi_eeprom_read_write_assertions
  #(.WRITE_CYCLE_COUNT(WRITE_CYCLE_COUNT)) chk (.*);
`default_nettype wire

// [tb/tb.sv]
/*
  self-checking bench for the eeprom block.
  assumes the master model drives the link and the bench drives clk_i side.
*/
`timescale 1ns/1ns
`default_nettype none
module tb;
  import eeprom_pkg::*;
  localparam int WCC = 600;
  logic clk_i = 1'b0;
  logic rst_i;
  logic status_load_i = 1'b0;
  logic [2:0] status_value_i = 3'h0;
  wire serial_clock_i, device_select_n_i, serial_in_i, serial_out_o, serial_out_en_o;
  wire write_busy_flag_o, write_enable_latch_o;
  wire status_write_lock_o, block_protect_hi_o, block_protect_lo_o;
  int error_cnt = 0;
  int checks = 0;
  int p;
  logic [7:0] mem[32];
  logic [7:0] q[$];
  logic [15:0] a;
  logic [2:0] v;
  always #2 clk_i = ~clk_i;
  // undriven output line idles at its pull-up level
  wire miso;
  assign miso = serial_out_en_o ? serial_out_o : 1'b1;
  spi_master_model m (.sck_o(serial_clock_i), .sel_n_o(device_select_n_i),
    .mosi_o(serial_in_i), .miso_i(miso));
  spi_eeprom_read_write #(.WRITE_CYCLE_COUNT(WCC)) uut (.*);
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[FAIL] %0t got %h want %h", $time, seen, exp);
    end
  endtask
  task automatic give_verdict;
    if (error_cnt == 0 && checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic ld(input logic [2:0] val);
    @(posedge clk_i);
    status_load_i <= 1'b1;
    status_value_i <= val;
    @(posedge clk_i);
    status_load_i <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic wr(input logic [15:0] ad, input logic [7:0] d[$], input int extra);
    m.xfer({OP_WRITE_DEFAULT, ad[15:8], ad[7:0], d}, 0, extra);
  endtask
  initial begin
    #200000;
    error_cnt++;
    give_verdict();
  end
  initial begin
    rst_i <= 1'b1;
    void'($urandom(32'h33A7));
    foreach (mem[i]) mem[i] = ERASED_BYTE;
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (4) @(posedge clk_i);
    check({status_write_lock_o, block_protect_hi_o, block_protect_lo_o}, STATUS_RESET);
    a = 16'($urandom);
    m.xfer({OP_READ_DEFAULT, a[15:8], a[7:0]}, 2, 0);
    foreach (m.rx[i]) check(m.rx[i], ERASED_BYTE);
    v = 3'($urandom);
    ld(v);
    check({status_write_lock_o, block_protect_hi_o, block_protect_lo_o}, v);
    ld(3'h0);
    p = $urandom_range(31);
    a = {5'($urandom), 11'(p)};
    for (int i = 0; i < 33; i++) q.push_back(8'($urandom));
    wr(a, q, 0);
    check(write_busy_flag_o, 1'b0);
    m.xfer({OP_WRITE_ENABLE_CMD_DEFAULT}, 0, 0);
    check(write_enable_latch_o, 1'b1);
    wr(a, q, 0);
    check(write_busy_flag_o, 1'b1);
    wr(16'h0100, {8'h3C}, 0);
    for (int i = 0; i < 33; i++) mem[(p + i) % 32] = q[i];
    m.xfer({OP_READ_DEFAULT, 8'h00, 8'h00}, 1, 0);
    check(m.rx[0], ERASED_BYTE);
    for (int i = 0; i < WCC + 50 && write_busy_flag_o; i++) @(posedge clk_i);
    check(write_busy_flag_o, 1'b0);
    check(write_enable_latch_o, 1'b0);
    m.xfer({OP_READ_DEFAULT, 8'hFF, 8'hFF}, 33, 0);
    check(m.rx[0], ERASED_BYTE);
    for (int i = 1; i < 33; i++) check(m.rx[i], mem[i - 1]);
    m.xfer({OP_WRITE_ENABLE_CMD_DEFAULT}, 0, 0);
    wr(16'h0040, {8'h00}, 3);
    check(write_busy_flag_o, 1'b0);
    check(write_enable_latch_o, 1'b1);
    for (int b = 1; b < 4; b++) begin
      ld(3'(b));
      wr(16'h07E0, {8'h00}, 0);
      check(write_busy_flag_o, 1'b0);
    end
    ld(3'h0);
    m.xfer({OP_READ_DEFAULT, 8'h07, 8'hE0}, 1, 0);
    check(m.rx[0], ERASED_BYTE);
    m.xfer({OP_READ_DEFAULT, 8'h01, 8'h00}, 1, 0);
    check(m.rx[0], ERASED_BYTE);
    give_verdict();
  end
endmodule
`default_nettype wire
